// ===== cca_ctrl.v
`default_nettype none
`include "cca_consts.vh"
// clear channel assessment control with a simple register port
module cca_ctrl (
    // clock and reset
    input  wire       ref_clk,
    input  wire       resetn,
    // register port, same clock
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [5:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // receiver state from radio core
    input  wire [4:0] trx_state,
    input  wire       shr_detect,
    input  wire       frame_end,
    // radio measurements, asynchronous to ref_clk
    input  wire       carrier_detect,
    input  wire [7:0] rx_power,
    // outputs
    output reg        measurement_ready_irq,
    output reg        preamble_detect_disable,
    output reg  [4:0] channel_sel
);
    ////////////////////////////////////////////////////////////////////////////
    // timing; products are worked out as integers, then cut to the counter width
    // the counter width must hold the longer of the two counts
    localparam integer          MEAS_INT  = `CCA_MEAS_US * `CCA_CLK_MHZ;
    localparam integer          ED_INT    = `CCA_MEAS_SYMS * `CCA_SYM_US * `CCA_CLK_MHZ;
    localparam [`CCA_CNT_W-1:0] MEAS_CYC  = MEAS_INT[`CCA_CNT_W-1:0];   // manual window
    localparam [`CCA_CNT_W-1:0] ED_CYC    = ED_INT[`CCA_CNT_W-1:0];     // automated run
    // reset images of the control and threshold registers
    localparam [7:0]            CTRL_RST  = `CCA_CTRL_RST;
    localparam [7:0]            THRES_RST = `CCA_THRES_RST;

    // state machine
    localparam [1:0] S_IDLE = 2'h0;   // no assessment pending
    localparam [1:0] S_MEAS = 2'h1;   // idle-listening timed measurement
    localparam [1:0] S_WAIT = 2'h2;   // waiting for automated energy run
    // code 2'h3 is unused and falls back to S_IDLE

    ////////////////////////////////////////////////////////////////////////////
    // register state
    reg       done_r;          // assess_complete_flag
    reg       idle_r;          // channel_idle_flag
    reg [1:0] mode_r;          // assess_mode_field
    reg [4:0] thres_r;         // energy_threshold_field
    reg [1:0] st_r;            // assessment state
    reg       ed_used_r;       // automated run already spent this frame
    reg       cs_seen_r;       // carrier seen during timed window
    reg [7:0] pk_r;            // peak power during timed window
    reg       req_r;           // request taken, one-cycle pulse
    // power synchroniser stages
    reg [7:0] p1_r;            // first capture, read only by p2_r
    reg [7:0] p2_r;            // second stage
    reg [7:0] p3_r;            // third stage
    reg [7:0] pw_r;            // agreed power level
    // internal nets
    wire      cs_s;            // carrier after synchroniser
    wire      ed_busy;         // automated run in progress
    wire      ed_done;         // automated run finished, one cycle
    wire      mt_done;         // manual window finished, one cycle
    wire      mt_busy;         // manual window in progress
    ////////////////////////////////////////////////////////////////////////////
    // decode helpers; both are used by every path that posts a result except carrier-only and not-receiving, so the
    // mode table and the threshold rule live in exactly one place each
    function busy_of;
        input [1:0] m;
        input       cs;
        input       en;
        begin
            case (m)
                `ASSESS_MODE_FIELD_ED:  busy_of = en;
                `ASSESS_MODE_FIELD_CS:  busy_of = cs;
                `ASSESS_MODE_FIELD_AND: busy_of = cs & en;
                default:       busy_of = cs | en;
            endcase
        end
    endfunction
    // energy above threshold; power counts above base level, 1 dB a step
    // base level is the zero of rx_power, so only twice the field is added
    function over_thr;
        input [7:0] p;
        input [4:0] t;
        begin
            over_thr = p > {2'h0, t, 1'b0};
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // synchronised carrier indication; the radio side runs on its own timing,
    // so the level passes three flops and only a stable value is used
    cca_sync3 u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .din     (carrier_detect),
        .dout    (cs_s)
    );
    // power sampled by three flops as well, held value after agreement;
    // a word that is still moving between stages is ignored until it settles,
    // so a torn multi-bit sample never reaches the peak detector
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            p1_r <= 8'h00;
            p2_r <= 8'h00;
            p3_r <= 8'h00;
            pw_r <= 8'h00;
        end else begin
            p1_r <= rx_power;
            p2_r <= p1_r;
            p3_r <= p2_r;
            if (p2_r == p3_r) begin
                pw_r <= p3_r;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // request decode and state checks; trx_state comes from logic on this
    // clock, so it is compared directly without a synchroniser
    wire wr_ctl   = reg_wr && (reg_addr == `CCA_ADDR_CONTROL);
    // writing the request bit is what starts an assessment
    wire new_req  = wr_ctl && reg_wdata[`CCA_BIT_REQ];
    wire in_rxon  = (trx_state == `CCA_ST_RX_ON);
    wire in_busy  = (trx_state == `CCA_ST_BUSY_RX);
    // a header starts a run only if the frame has not had one yet
    wire ed_start = shr_detect && !ed_used_r && !preamble_detect_disable;

    // automated energy run after frame header; it is never aborted, a frame
    // that ends early still lets the run finish and release S_WAIT
    cca_timer u_ed (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (ed_start),
        .abort   (1'b0),
        .len     (ED_CYC),
        .busy    (ed_busy),
        .done    (ed_done)
    );

    // manual idle-listening measurement window; a fresh request drops the
    // running window first, so a stale finish can never close the new one
    cca_timer u_meas (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (req_r && in_rxon),
        .abort   (new_req),
        .len     (MEAS_CYC),
        .busy    (mt_busy),
        .done    (mt_done)
    );
    ////////////////////////////////////////////////////////////////////////////
    // configuration registers; the request bit itself is never stored, it only
    // makes the one-cycle req_r, which is why it always reads back as zero
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r                  <= CTRL_RST[`ASSESS_MODE_FIELD_HI:`ASSESS_MODE_FIELD_LO];
            channel_sel             <= CTRL_RST[`CCA_CHAN_HI:0];
            thres_r                 <= THRES_RST[`CCA_THR_HI:0];
            preamble_detect_disable <= 1'b0;
            req_r                   <= 1'b0;
        end else begin
            req_r <= new_req;
            if (wr_ctl) begin
                mode_r      <= reg_wdata[`ASSESS_MODE_FIELD_HI:`ASSESS_MODE_FIELD_LO];
                channel_sel <= reg_wdata[`CCA_CHAN_HI:0];
            end
            // only the five low bits of the threshold register exist
            if (reg_wr && reg_addr == `CCA_ADDR_THRES) begin
                thres_r <= reg_wdata[`CCA_THR_HI:0];
            end
            // preamble disable keeps the receiver in idle listening
            if (reg_wr && reg_addr == `CCA_ADDR_RXSYN) begin
                preamble_detect_disable <= reg_wdata[`CCA_BIT_PDTDIS];
            end
        end
    end

    // one automated run per frame; frame end re-arms. a header that arrives
    // while preamble detection is disabled is ignored and spends nothing
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ed_used_r <= 1'b0;
        end else if (ed_start) begin
            ed_used_r <= 1'b1;
        end else if (frame_end) begin
            ed_used_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // peak hold over window, also tracks frame energy while waiting.
    // a request reloads the peak from the present level; the limitation is
    // that energy seen before the request in busy receive is forgotten.
    // cs_seen_r collects any carrier while a window or run is open
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pk_r      <= 8'h00;
            cs_seen_r <= 1'b0;
        end else if (req_r || ed_start) begin
            pk_r      <= pw_r;
            cs_seen_r <= cs_s;
        end else if (mt_busy || ed_busy) begin
            if (pw_r > pk_r) begin
                pk_r <= pw_r;
            end
            cs_seen_r <= cs_seen_r | cs_s;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // assessment state machine and flags
    //   S_IDLE: takes req_r and picks the path from trx_state and the mode
    //   S_MEAS: timed window in idle listening, result when the timer ends
    //   S_WAIT: busy receive while the automated run is going; result at its end
    // every path that finishes raises the ready pulse for exactly one cycle
    // a new request overrides every state and clears both flags first
    // combined verdict over the window or run that has just closed
    wire busy_now = busy_of(mode_r, cs_seen_r | cs_s, over_thr(pk_r, thres_r));
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r                  <= S_IDLE;
            done_r                <= 1'b0;
            idle_r                <= 1'b0;
            measurement_ready_irq <= 1'b0;
        end else begin
            measurement_ready_irq <= 1'b0;
            if (new_req) begin
                // clear wins; a finishing measurement is superseded
                done_r <= 1'b0;
                idle_r <= 1'b0;
                st_r   <= S_IDLE;
            end else begin
                case (st_r)
                    S_IDLE: begin
                        if (req_r) begin
                            if (in_rxon) begin
                                // idle listening: open the 140 us window
                                st_r <= S_MEAS;
                            end else if (in_busy && mode_r == `ASSESS_MODE_FIELD_CS) begin
                                // carrier only: current carrier decides, energy and
                                // any carrier left over from an old window are ignored
                                done_r <= 1'b1;
                                idle_r <= ~cs_s;
                                measurement_ready_irq <= 1'b1;
                            end else if (in_busy && ed_busy) begin
                                // energy modes need the automated result;
                                // early pulse, result follows later
                                measurement_ready_irq <= 1'b1;
                                st_r <= S_WAIT;
                            end else if (in_busy) begin
                                // run already over: its result answers at once
                                done_r <= 1'b1;
                                idle_r <= ~busy_now;
                                measurement_ready_irq <= 1'b1;
                            end else begin
                                // not receiving: nothing measured, busy result stays
                                done_r <= 1'b1;
                                measurement_ready_irq <= 1'b1;
                            end
                        end
                    end
                    S_MEAS: begin
                        // the timer pulses once, after the full window
                        if (mt_done) begin
                            done_r <= 1'b1;
                            idle_r <= ~busy_now;
                            measurement_ready_irq <= 1'b1;
                            st_r <= S_IDLE;
                        end
                    end
                    S_WAIT: begin
                        // !ed_busy also covers a run that ended before we got here
                        if (ed_done || !ed_busy) begin
                            done_r <= 1'b1;
                            idle_r <= ~busy_now;
                            measurement_ready_irq <= 1'b1;
                            st_r <= S_IDLE;
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
            // otherwise flags hold until next request
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // read data, registered; request bit always reads zero. the value stays
    // on reg_rdata until the next read strobe, so the host may sample late;
    // reserved status bit 5 reads as zero
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CCA_ADDR_STATUS:  reg_rdata <= {done_r, idle_r, 1'b0, trx_state};
                `CCA_ADDR_CONTROL: reg_rdata <= {1'b0, mode_r, channel_sel};
                `CCA_ADDR_THRES:   reg_rdata <= {3'h0, thres_r};
                `CCA_ADDR_RXSYN:   reg_rdata <= {preamble_detect_disable, 7'h00};
                // unmapped addresses read as zero
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== cca_consts.vh
`ifndef CCA_CONSTS_VH
`define CCA_CONSTS_VH
`define CCA_ADDR_STATUS    6'h01
`define CCA_ADDR_CONTROL   6'h08
`define CCA_ADDR_THRES     6'h09
`define CCA_ADDR_RXSYN     6'h15
`define CCA_BIT_DONE       7
`define CCA_BIT_IDLE       6
`define CCA_BIT_REQ        7
`define CCA_BIT_PDTDIS     7
`define ASSESS_MODE_FIELD_HI        6
`define ASSESS_MODE_FIELD_LO        5
`define CCA_THR_HI         4
`define CCA_CHAN_HI        4
`define ASSESS_MODE_FIELD_OR        2'h0
`define ASSESS_MODE_FIELD_ED        2'h1
`define ASSESS_MODE_FIELD_CS        2'h2
`define ASSESS_MODE_FIELD_AND       2'h3
`define CCA_CTRL_RST       8'h2b
`define CCA_THRES_RST      8'h07
`define CCA_CLK_MHZ        25
`define CCA_MEAS_US        140
`define CCA_SYM_US         16
`define CCA_MEAS_SYMS      8
`define CCA_CNT_W          12
`define CCA_ST_RX_ON       5'h06
`define CCA_ST_BUSY_RX     5'h01
`endif

// ===== cca_sync3.v
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module cca_sync3 (
    // clock and reset
    input  wire ref_clk,
    input  wire resetn,
    // async level in, filtered level out
    input  wire din,
    output reg  dout
);
    reg s1_r;   // metastability catcher, read only by s2
    reg s2_r;
    reg s3_r;
    // shift and compare
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// ===== cca_timer.v
`default_nettype none
`include "cca_consts.vh"
// down counter: loads a length, pulses done when it reaches zero
module cca_timer (
    // clock and reset
    input  wire                  ref_clk,
    input  wire                  resetn,
    // control
    input  wire                  start,
    input  wire                  abort,
    input  wire [`CCA_CNT_W-1:0] len,
    // status
    output reg                   busy,
    output reg                   done
);
    reg [`CCA_CNT_W-1:0] cnt_r;   // cycles left
    // count down while busy; start wins over a running count
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= {`CCA_CNT_W{1'b0}};
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                cnt_r <= len;
                busy  <= 1'b1;
            end else if (busy) begin
                if (cnt_r == {{(`CCA_CNT_W-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_r <= cnt_r - {{(`CCA_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ===== cca_props.sv
`default_nettype none
`include "cca_consts.vh"
// port-level checker for the assessment control block
module cca_props (
    // clock and reset
    input wire       ref_clk,
    input wire       resetn,
    // register port
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // receiver state and outputs
    input wire [4:0] trx_state,
    input wire       measurement_ready_irq,
    input wire       preamble_detect_disable,
    input wire [4:0] channel_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    logic        req;    // request write seen this cycle
    logic        rxon_r; // last request came in idle listening
    logic        seen_r; // ready pulse seen since last request
    logic [12:0] cnt_r;  // cycles since last request, saturating
    assign req = reg_wr && reg_addr == `CCA_ADDR_CONTROL && reg_wdata[`CCA_BIT_REQ];
    // age of the last request; too long for a repetition, so counted here
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rxon_r <= 1'b0;
            seen_r <= 1'b0;
            cnt_r  <= 13'h0000;
        end else if (req) begin
            rxon_r <= trx_state == `CCA_ST_RX_ON;
            seen_r <= 1'b0;
            cnt_r  <= 13'h0000;
        end else begin
            if (cnt_r != 13'h1fff) cnt_r <= cnt_r + 13'h0001;
            if (measurement_ready_irq) seen_r <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_norx_irq;
        req && trx_state != `CCA_ST_RX_ON && trx_state != `CCA_ST_BUSY_RX
            |-> ##[1:3] measurement_ready_irq;
    endproperty
    a_norx_irq: assert property (p_norx_irq) else $error("no ready pulse outside receive");
    property p_cs_fast;
        req && trx_state == `CCA_ST_BUSY_RX
            && reg_wdata[`ASSESS_MODE_FIELD_HI:`ASSESS_MODE_FIELD_LO] == `ASSESS_MODE_FIELD_CS
            |-> ##[1:3] measurement_ready_irq;
    endproperty
    a_cs_fast: assert property (p_cs_fast) else $error("carrier-only result late");
    property p_rxon_early;
        measurement_ready_irq && rxon_r && !seen_r |-> cnt_r >= 13'd3499 && cnt_r <= 13'd3503;
    endproperty
    a_rxon_early: assert property (p_rxon_early) else $error("listening result off time");
    property p_rxon_due;
        rxon_r && cnt_r == 13'd3505 |-> seen_r;
    endproperty
    a_rxon_due: assert property (p_rxon_due) else $error("listening result missing");
    property p_irq_pulse;
        measurement_ready_irq |=> !measurement_ready_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("ready pulse too long");
    property p_rd_stat;
        $past(reg_rd) && $past(reg_addr) == `CCA_ADDR_STATUS
            |-> reg_rdata[5] == 1'b0 && reg_rdata[4:0] == $past(trx_state);
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("status low bits wrong");
    property p_rd_hold;
        !$past(reg_rd) |-> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_chan;
        reg_wr && reg_addr == `CCA_ADDR_CONTROL |=> channel_sel == $past(reg_wdata[4:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not taken");
    property p_pdd;
        reg_wr && reg_addr == `CCA_ADDR_RXSYN
            |=> preamble_detect_disable == $past(reg_wdata[`CCA_BIT_PDTDIS]);
    endproperty
    a_pdd: assert property (p_pdd) else $error("preamble disable not taken");
    c_rxon: cover property (req && trx_state == `CCA_ST_RX_ON);
    c_busy: cover property (req && trx_state == `CCA_ST_BUSY_RX);
    c_done: cover property (measurement_ready_irq && rxon_r);
endmodule
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0;
    logic       resetn, reg_wr, reg_rd, shr_detect, frame_end, carrier_detect;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, rx_power, d;
    logic [4:0] trx_state;
    wire  [7:0] reg_rdata;
    wire        measurement_ready_irq, preamble_detect_disable;
    wire  [4:0] channel_sel;
    int         err_total, samples_checked, cycles;
    // mode, carrier, power and expected idle flag per case; threshold is 10
    logic [1:0] t_mode [8] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3};
    logic       t_cs   [8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] t_pw   [8] = '{8'h0b, 8'h0a, 8'h00, 8'h14, 8'h0b, 8'h0a, 8'h0a, 8'h0b};
    logic       t_idle [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    cca_ctrl i_cca_ctrl (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .trx_state(trx_state), .shr_detect(shr_detect), .frame_end(frame_end),
        .carrier_detect(carrier_detect), .rx_power(rx_power),
        .measurement_ready_irq(measurement_ready_irq),
        .preamble_detect_disable(preamble_detect_disable), .channel_sel(channel_sel));
    ////////////////////////////////////////////////////////////////
    always #20 ref_clk = ~ref_clk;
    // hang guard: the whole run needs about 32000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes, launched and dropped on rising edges
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        v = reg_rdata;   // stands since the strobe's edge, unchanged at this one
    endtask
    // bounded wait for the one-cycle ready pulse
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (measurement_ready_irq !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        chk({7'h00, measurement_ready_irq}, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        {reg_wr, reg_rd, shr_detect, frame_end, carrier_detect} = 5'h00;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        rx_power = 8'h00;
        trx_state = 5'h06;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(6'h08, d);
        chk(d, 8'h2b);
        rd(6'h01, d);
        chk(d, 8'h06);
        wr(6'h09, 8'h05);
        rd(6'h09, d);
        chk(d, 8'h05);
        // idle listening: every mode, each on both sides of the threshold
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            carrier_detect <= t_cs[i];
            rx_power <= t_pw[i];
            repeat (8) @(posedge ref_clk);
            wr(6'h08, {1'b1, t_mode[i], 5'h0b});
            rd(6'h01, d);
            chk(d, 8'h06);
            rd(6'h08, d);
            chk(d, {1'b0, t_mode[i], 5'h0b});
            wait_irq(3600);
            rd(6'h01, d);
            chk(d, {1'b1, t_idle[i], 6'h06});
            carrier_detect <= ~t_cs[i];
            rx_power <= 8'h40 - t_pw[i];
            repeat (8) @(posedge ref_clk);
            rd(6'h01, d);
            chk(d, {1'b1, t_idle[i], 6'h06});
        end
        // busy receive, carrier only: result at once, carrier makes it busy
        trx_state <= 5'h01;
        carrier_detect <= 1'b1;
        rx_power <= 8'h00;
        repeat (8) @(posedge ref_clk);   // carrier through its synchroniser
        wr(6'h08, 8'hcb);
        wait_irq(8);
        rd(6'h01, d);
        chk(d, 8'h81);
        // new frame: energy run after the header delays the result
        carrier_detect <= 1'b0;
        frame_end <= 1'b1;
        @(posedge ref_clk);
        frame_end <= 1'b0;
        shr_detect <= 1'b1;
        @(posedge ref_clk);
        shr_detect <= 1'b0;
        wr(6'h08, 8'hab);
        wait_irq(8);
        rd(6'h01, d);
        chk(d, 8'h01);
        wait_irq(3400);
        rd(6'h01, d);
        chk(d, 8'hc1);
        // a second header in the same frame starts no new run
        @(posedge ref_clk);
        shr_detect <= 1'b1;
        @(posedge ref_clk);
        shr_detect <= 1'b0;
        wr(6'h08, 8'hab);
        wait_irq(8);
        rd(6'h01, d);
        chk(d, 8'hc1);
        // outside receive states: done with busy result, nothing measured
        trx_state <= 5'h08;
        wr(6'h08, 8'hab);
        wait_irq(8);
        rd(6'h01, d);
        chk(d, 8'h88);
        wr(6'h15, 8'h80);
        @(posedge ref_clk);
        chk({7'h00, preamble_detect_disable}, 8'h01);
        wr(6'h15, 8'h00);
        @(posedge ref_clk);
        chk({7'h00, preamble_detect_disable}, 8'h00);
        finish_test();
    end
endmodule
bind cca_ctrl cca_props i_cca_props (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .trx_state(trx_state), .measurement_ready_irq(measurement_ready_irq),
    .preamble_detect_disable(preamble_detect_disable), .channel_sel(channel_sel));
`default_nettype wire
